/* hw/tiv_timer.sv */
// One timer channel with single-shot, frequency and pulse-width modes behind APB.
// Assumes gate_n and ext_reset_n are asynchronous pins; gate_n is low-active.
`timescale 1ns/1ps
`include "tiv_map.svh"
module tiv_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gate_n,
    input wire logic ext_reset_n,
    output logic pulse_out,
    output logic irq
);
    logic [7:0] ctrl_reg;
    logic [15:0] latch_reg;
    logic [15:0] count_reg;
    logic run_reg;
    logic flag_reg;
    logic exp_sticky_reg;
    logic [1:0] mask_reg;
    logic gate_prev_reg;
    logic gate_s;
    logic ext_rst_s;
    logic shot_done_reg;
    logic wr_acc;
    logic latch_wr;
    logic timer_rst;
    logic gate_fall;
    logic gate_rise;
    logic expiry;
    logic init;
    logic run_set;
    logic run_clr;
    logic flag_set;
    logic mode_a;
    logic mode_b;
    logic src;
    tiv_pkg::tiv_mode_t mode;

    // Gate and external reset arrive from pins, so both are synchronised first.
    tiv_sync u_gate_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(~gate_n),
        .sync_out(gate_s)
    );
    tiv_sync u_rst_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(~ext_reset_n),
        .sync_out(ext_rst_s)
    );

    // Edge detection works on the synchronised gate; gate_s high means the pin is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_prev_reg <= 1'b0;
        end else begin
            gate_prev_reg <= gate_s;
        end
    end

    // Decoded control fields.
    always_comb begin
        mode_a = ctrl_reg[`TIV_F_MODEA];
        mode_b = ctrl_reg[`TIV_F_MODEB];
        src = ctrl_reg[`TIV_F_SRC];
        if (mode_a && mode_b) begin
            mode = tiv_pkg::TIV_PWID;
        end else if (mode_a) begin
            mode = tiv_pkg::TIV_FREQ;
        end else if (src) begin
            mode = tiv_pkg::TIV_SHOT;
        end else begin
            mode = tiv_pkg::TIV_CONT;
        end
    end

    // Event terms used by the mode equations.
    assign wr_acc = psel && penable && pwrite;
    assign latch_wr = wr_acc && (paddr == `TIV_LATCH_OFS);
    assign timer_rst = ctrl_reg[`TIV_F_IRST] || ext_rst_s;
    assign gate_fall = gate_s && !gate_prev_reg;
    assign gate_rise = !gate_s && gate_prev_reg;
    assign expiry = run_reg && (count_reg == 16'h0000);

    // Counter initialisation per mode.
    always_comb begin
        init = timer_rst;
        case (mode)
            tiv_pkg::TIV_SHOT,
            tiv_pkg::TIV_CONT: begin
                init = gate_fall || timer_rst || (latch_wr && !mode_b);
            end
            tiv_pkg::TIV_FREQ: begin
                if (!src) begin
                    init = timer_rst || (gate_fall && !flag_reg && (!run_reg || expiry));
                end else begin
                    init = timer_rst || (gate_fall && !flag_reg);
                end
            end
            tiv_pkg::TIV_PWID: begin
                init = timer_rst || (gate_fall && !flag_reg);
            end
            default: begin
                init = timer_rst;
            end
        endcase
    end

    // Count-run set and clear, and the interrupt flag cause.
    always_comb begin
        run_set = 1'b0;
        run_clr = 1'b0;
        flag_set = 1'b0;
        case (mode)
            tiv_pkg::TIV_FREQ: begin
                run_set = gate_fall && !latch_wr && !timer_rst && !flag_reg;
                run_clr = latch_wr || timer_rst || flag_reg;
                // Source 0: gate fall ends an unexpired count; source 1: expiry comes first.
                flag_set = src ? (expiry && !gate_fall) : (gate_fall && run_reg && !expiry);
            end
            tiv_pkg::TIV_PWID: begin
                run_set = gate_fall && !latch_wr && !timer_rst && !flag_reg;
                run_clr = latch_wr || flag_reg || timer_rst || !gate_s;
                flag_set = src ? (expiry && !gate_rise) : (gate_rise && run_reg && !expiry);
            end
            default: begin
                run_set = init && !timer_rst;
                run_clr = timer_rst || (expiry && mode == tiv_pkg::TIV_SHOT);
                flag_set = expiry;
            end
        endcase
    end

    // Counter and run flip-flop; a clear in the same cycle beats a set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= `TIV_LATCH_RST;
            run_reg <= 1'b0;
        end else begin
            // A latch write that initialises must load the word being written, not the stale latch.
            if (init && latch_wr) begin
                count_reg <= pwdata[15:0];
            end else if (init) begin
                count_reg <= latch_reg;
            end else if (run_reg) begin
                count_reg <= count_reg - 16'h0001;
            end
            if (run_clr) begin
                run_reg <= 1'b0;
            end else if (run_set) begin
                run_reg <= 1'b1;
            end else if (expiry && mode == tiv_pkg::TIV_FREQ && !src) begin
                run_reg <= 1'b1; // Expiry before the gate recycles the count.
            end
        end
    end

    // Interrupt flag is cleared only by a timer reset; a set event wins over it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
            exp_sticky_reg <= 1'b0;
        end else begin
            if (flag_set) begin
                flag_reg <= 1'b1;
            end else if (timer_rst) begin
                flag_reg <= 1'b0;
            end
            if (expiry) begin
                exp_sticky_reg <= 1'b1;
            end else if (wr_acc && paddr == `TIV_STATUS_OFS && pwdata[`TIV_ST_EXP]) begin
                exp_sticky_reg <= 1'b0;
            end
        end
    end

    // Single-shot output: one pulse, then low until the next initialisation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shot_done_reg <= 1'b0;
            pulse_out <= 1'b0;
        end else begin
            if (init) begin
                shot_done_reg <= 1'b0;
            end else if (expiry) begin
                shot_done_reg <= 1'b1;
            end
            pulse_out <= (mode == tiv_pkg::TIV_SHOT) && ctrl_reg[`TIV_F_OE] && run_reg && !shot_done_reg;
        end
    end

    // Software registers. Latch writes are captured on the APB access edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TIV_CTRL_RST;
            latch_reg <= `TIV_LATCH_RST;
            mask_reg <= 2'h0;
        end else if (wr_acc) begin
            if (paddr == `TIV_CTRL_OFS) begin
                ctrl_reg <= pwdata[7:0];
            end else if (paddr == `TIV_LATCH_OFS) begin
                latch_reg <= pwdata[15:0];
            end else if (paddr == `TIV_MASK_OFS) begin
                mask_reg <= pwdata[1:0];
            end
        end
    end

    // Read mux and answer; the slave always replies in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == `TIV_CTRL_OFS) begin
                    prdata <= {24'h000000, ctrl_reg};
                end else if (paddr == `TIV_LATCH_OFS) begin
                    prdata <= {16'h0000, latch_reg};
                end else if (paddr == `TIV_STATUS_OFS) begin
                    prdata <= {30'h0, exp_sticky_reg, flag_reg};
                end else if (paddr == `TIV_MASK_OFS) begin
                    prdata <= {30'h0, mask_reg};
                end else if (paddr == `TIV_COUNT_OFS) begin
                    prdata <= {15'h0000, run_reg, count_reg};
                end else begin
                    pslverr <= 1'b1; // Unmapped addresses answer with an error.
                end
            end
        end
    end

    // Level interrupt from the masked status bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |({exp_sticky_reg, flag_reg} & mask_reg);
        end
    end

    // The counter expires only while running, and the flag never drops without reset.
    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        (flag_reg && !timer_rst) |=> flag_reg;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without reset");

    property p_freq_stop;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_FREQ && (latch_wr || timer_rst)) |=> !run_reg;
    endproperty
    a_freq_stop: assert property (p_freq_stop) else $error("run not cleared in freq mode");

    property p_pw_gate_stop;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_PWID && !gate_s) |=> !run_reg;
    endproperty
    a_pw_gate_stop: assert property (p_pw_gate_stop) else $error("run not cleared on gate high");

    property p_dec;
        @(posedge pclk) disable iff (!presetn)
        (run_reg && !init) |=> (count_reg == $past(count_reg) - 16'h0001);
    endproperty
    a_dec: assert property (p_dec) else $error("counter did not decrement");

    property p_init_load;
        @(posedge pclk) disable iff (!presetn)
        (timer_rst && !wr_acc) |=> (count_reg == $past(latch_reg));
    endproperty
    a_init_load: assert property (p_init_load) else $error("reset did not load counter");

    property p_start;
        @(posedge pclk) disable iff (!presetn)
        (mode_a && gate_fall && !latch_wr && !timer_rst && !flag_reg && !run_clr) |=> run_reg;
    endproperty
    a_start: assert property (p_start) else $error("count did not start on gate fall");

    property p_pw_flag;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_PWID && !src && gate_rise && run_reg && !expiry) |=> flag_reg;
    endproperty
    a_pw_flag: assert property (p_pw_flag) else $error("pulse-width flag missing");

    property p_freq_flag;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_FREQ && src && expiry && !gate_fall) |=> flag_reg;
    endproperty
    a_freq_flag: assert property (p_freq_flag) else $error("frequency flag missing");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        (flag_reg && mask_reg[`TIV_ST_FLAG]) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq not raised");

    // A latch write that initialises the counter hands over the written value at once.
    property p_latch_load;
        @(posedge pclk) disable iff (!presetn)
        (latch_wr && init) |=> (count_reg == $past(pwdata[15:0]));
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch write did not load counter");

    // The single shot restarts on a latch write only while mode bit B is clear.
    property p_shot_init;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_SHOT && latch_wr && !mode_b && !timer_rst && !expiry) |=> run_reg;
    endproperty
    a_shot_init: assert property (p_shot_init) else $error("latch write did not start single shot");

    // Expiry in single shot ends the run, and the pulse drops one cycle later.
    sequence s_shot_expiry;
        mode == tiv_pkg::TIV_SHOT && expiry;
    endsequence

    property p_shot_stop;
        @(posedge pclk) disable iff (!presetn)
        s_shot_expiry |=> !run_reg ##1 !pulse_out;
    endproperty
    a_shot_stop: assert property (p_shot_stop) else $error("single shot kept running");

    // A pending flag in either time-interval mode holds the count stopped.
    sequence s_flag_seen;
        mode_a && flag_reg;
    endsequence

    property p_no_run_flagged;
        @(posedge pclk) disable iff (!presetn)
        s_flag_seen |=> !run_reg;
    endproperty
    a_no_run_flagged: assert property (p_no_run_flagged) else $error("count ran with flag pending");

    // With source 0 an expiry before the gate keeps the frequency count going.
    property p_freq_recycle;
        @(posedge pclk) disable iff (!presetn)
        (mode == tiv_pkg::TIV_FREQ && !src && expiry && !run_clr) |=> run_reg;
    endproperty
    a_freq_recycle: assert property (p_freq_recycle) else $error("frequency count did not recycle");
endmodule // tiv_timer

/* hw/tiv_map.svh */
// Constants for the timer interval-mode channel: register offsets, fields, resets, timing.
// Assumes an APB slave with 32-bit data on a 40 MHz pclk.
// How it works
// - Pulse-width mode: source bit picks expiry or gate rise as flag cause.
// - Mode A=1, B=0 selects frequency measurement behaviour.
// - Mode A=1, B=1 selects pulse-width comparison behaviour.
// - Single shot needs A=0, source bit 1, output enable 1 for one pulse.
// - Single shot initialises on gate fall, reset, or latch write when B=0.
// - Frequency source 1 and pulse-width: init on unflagged gate fall or reset.
// - Interval modes start counting on gate fall without write, reset or flag.
// - Frequency mode stops counting on latch write, reset or flag.
// - Frequency flag: gate fall before expiry (src 0) or expiry first (src 1).
// - Pulse-width stops counting on write, flag, reset, or gate high.
// - Pulse-width flag: gate rise before expiry (src 0) or expiry first (src 1).
// - A host write to the latch register is the latch-write event.
// - Only timer reset (internal bit or external pin) clears flag and initialises.
// - External gate and reset pass a synchroniser before use.
`ifndef TIV_MAP_SVH
`define TIV_MAP_SVH
`define TIV_CTRL_OFS 12'h000
`define TIV_LATCH_OFS 12'h004
`define TIV_STATUS_OFS 12'h008
`define TIV_MASK_OFS 12'h00c
`define TIV_COUNT_OFS 12'h010
`define TIV_CTRL_RST 8'h01
`define TIV_LATCH_RST 16'hffff
`define TIV_F_IRST 0
`define TIV_F_WIDTH 2
`define TIV_F_MODEA 3
`define TIV_F_MODEB 4
`define TIV_F_SRC 5
`define TIV_F_OE 7
`define TIV_ST_FLAG 0
`define TIV_ST_EXP 1
`define TIV_SYNC_STAGES 2
`endif

/* hw/tiv_pkg.sv */
// Types for the timer interval-mode channel.
// Assumes tiv_map.svh supplies all numeric constants.
package tiv_pkg;
    typedef enum logic [3:0] {
        TIV_CONT = 4'b0001,
        TIV_SHOT = 4'b0010,
        TIV_FREQ = 4'b0100,
        TIV_PWID = 4'b1000
    } tiv_mode_t;
endpackage

/* hw/tiv_sync.sv */
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is free of glitches shorter than a pclk period.
`timescale 1ns/1ps
module tiv_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // tiv_sync

/* dv/tiv_far_end.sv */
// Far-side model of the timer channel: the gate source and the external reset switch.
// Assumes its tasks are called from the bench just after a rising edge of pclk.
`timescale 1ns/1ps
module tiv_far_end (
    input wire logic pclk,
    output logic gate_n,
    output logic ext_reset_n
);
    // Both pins idle high; the gate source always drives, so no pull is needed.
    initial begin
        gate_n = 1'b1;
        ext_reset_n = 1'b1;
    end

    // The pin changes at the caller's edge; the timer must synchronise it itself.
    task automatic set_gate(input logic v);
        gate_n <= v;
    endtask

    // Held low for four cycles so that the two-flop synchroniser surely sees it.
    task automatic ext_pulse();
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge pclk);
        ext_reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule // tiv_far_end

/* dv/tb.sv */
// Self-checking bench for the timer interval-mode channel over APB.
// Assumes tiv_timer answers with zero wait states and tiv_far_end drives the pins.
`timescale 1ns/1ps
`include "tiv_map.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic gate_n, ext_reset_n, pulse_out, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int fail_count = 0;
    int checks = 0;
    int hi;

    tiv_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_n(gate_n), .ext_reset_n(ext_reset_n), .pulse_out(pulse_out), .irq(irq));
    tiv_far_end far (.pclk(pclk), .gate_n(gate_n), .ext_reset_n(ext_reset_n));

    // A 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; an idle cycle follows so that psel is never assigned twice at one edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i == 40) begin
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(q & m, x);
    endtask

    // The interrupt output is registered, so give it a few edges to settle.
    task automatic irq_is(input logic x);
        tick(3);
        chk({31'h0, irq}, {31'h0, x});
    endtask

    // Set a mode under timer reset, start with a gate fall, apply a second gate action
    // (1: another fall, 2: a rise), then check the flag and the run bit.
    task automatic run_case(input logic [7:0] c, input logic [15:0] n, input int act,
        input logic fl, input logic rn);
        apb(1'b1, `TIV_CTRL_OFS, {24'h0, c | 8'h01});
        apb(1'b1, `TIV_LATCH_OFS, {16'h0, n});
        apb(1'b1, `TIV_CTRL_OFS, {24'h0, c});
        tick(8);
        far.set_gate(1'b0);
        tick(20);
        if (act == 1) begin
            far.set_gate(1'b1);
            tick(8);
            far.set_gate(1'b0);
        end
        if (act == 2) far.set_gate(1'b1);
        tick(60);
        // With the flag pending a further gate fall must neither start nor reload.
        if (fl) begin
            far.set_gate(1'b1);
            tick(8);
            far.set_gate(1'b0);
            tick(8);
        end
        rd(`TIV_STATUS_OFS, {31'h0, fl}, 32'h1);
        rd(`TIV_COUNT_OFS, {15'h0, rn, 16'h0}, 32'h10000);
        apb(1'b1, `TIV_LATCH_OFS, {16'h0, n});
        rd(`TIV_COUNT_OFS, 32'h0, 32'h10000);
        far.set_gate(1'b1);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then an unmapped read that must be refused.
        rd(`TIV_CTRL_OFS, {24'h0, `TIV_CTRL_RST}, 32'hff);
        rd(`TIV_LATCH_OFS, {16'h0, `TIV_LATCH_RST}, 32'hffff);
        rd(`TIV_COUNT_OFS, 32'h0000ffff, 32'h1ffff);
        rd(`TIV_STATUS_OFS, 32'h0, 32'h3);
        rd(12'h040, 32'h0, 32'hffffffff);
        chk({31'h0, e}, 32'h1);
        // Each time-interval mode and source setting, with the gate acting early or not at all.
        run_case(8'h08, 16'd200, 1, 1'b1, 1'b0);
        far.ext_pulse();
        rd(`TIV_STATUS_OFS, 32'h0, 32'h1);
        run_case(8'h08, 16'd4, 0, 1'b0, 1'b1);
        run_case(8'h28, 16'd200, 1, 1'b0, 1'b1);
        run_case(8'h18, 16'd200, 2, 1'b1, 1'b0);
        run_case(8'h38, 16'd200, 2, 1'b0, 1'b0);
        run_case(8'h38, 16'd4, 0, 1'b1, 1'b0);
        run_case(8'h28, 16'd4, 0, 1'b1, 1'b0);
        // Interrupt masking and the write-one-to-clear expiry bit; the flag is still set.
        apb(1'b1, `TIV_MASK_OFS, 32'h0);
        irq_is(1'b0);
        apb(1'b1, `TIV_MASK_OFS, 32'h2);
        irq_is(1'b1);
        apb(1'b1, `TIV_STATUS_OFS, 32'h2);
        irq_is(1'b0);
        apb(1'b1, `TIV_MASK_OFS, 32'h1);
        irq_is(1'b1);
        apb(1'b1, `TIV_CTRL_OFS, 32'h29);
        irq_is(1'b0);
        // Single shot: one pulse after a gate fall, then the output stays low.
        apb(1'b1, `TIV_CTRL_OFS, 32'ha1);
        apb(1'b1, `TIV_LATCH_OFS, 32'h3);
        apb(1'b1, `TIV_CTRL_OFS, 32'ha0);
        far.set_gate(1'b0);
        hi = 0;
        repeat (80) begin
            @(posedge pclk);
            if (pulse_out === 1'b1) hi++;
        end
        chk({31'h0, hi > 0}, 32'h1);
        chk({31'h0, pulse_out}, 32'h0);
        // A latch write with mode bit B clear starts the single shot again.
        apb(1'b1, `TIV_LATCH_OFS, 32'hc8);
        rd(`TIV_COUNT_OFS, 32'h10000, 32'h10000);
        // Continuous mode keeps counting through expiry and raises the flag.
        apb(1'b1, `TIV_CTRL_OFS, 32'h11);
        apb(1'b1, `TIV_LATCH_OFS, 32'h3);
        apb(1'b1, `TIV_CTRL_OFS, 32'h10);
        far.set_gate(1'b1);
        tick(8);
        far.set_gate(1'b0);
        tick(20);
        rd(`TIV_COUNT_OFS, 32'h10000, 32'h10000);
        rd(`TIV_STATUS_OFS, 32'h1, 32'h1);
        give_verdict();
    end
endmodule // tb
